// file: verilog/ducc_top.sv
`timescale 1ns/10ps

module ducc_top (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic        i_wr_en,
	input  wire logic [4:0]  i_wr_addr,
	input  wire logic [39:0] i_wr_data,
	input  wire logic [4:0]  i_rd_addr,
	output logic      [39:0] o_rd_data,
	input  wire logic        i_update,
	input  wire logic [1:0]  i_profile_select,
	input  wire logic        i_keying_input,
	input  wire logic        i_sync_in,
	input  wire logic [13:0] i_amplitude_scale_factor,
	input  wire logic [31:0] i_ram_word,
	input  wire logic [1:0]  i_internal_profile,
	input  wire logic [13:0] i_sample,
	output logic [1:0]       o_profile,
	output logic             o_ram_active,
	output logic [31:0]      o_ram_freq_word,
	output logic [31:0]      o_ram_phase_word,
	output logic             o_ram_freq_valid,
	output logic             o_ram_phase_valid,
	output logic [31:0]      o_tuning_word_one,
	output logic             o_sweep_active,
	output logic [31:0]      o_sweep_delta,
	output logic [7:0]       o_sweep_rate,
	output logic [13:0]      o_dac_sample,
	output logic [13:0]      o_keying_scalar,
	output logic             o_auto_sync_active,
	output logic             o_sync_align
);

	// ==========================================
	// shadow (serial) and active register copies
	logic [31:0] ctrl_shadow_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] tuning_shadow_reg;
	logic [31:0] tuning_reg;
	logic [39:0] fall_shadow_reg;
	logic [39:0] fall_reg;
	logic [39:0] rise_shadow_reg;
	logic [39:0] rise_reg;

	ducc_pkg::ducc_ctrl_t     ctrl;
	ducc_pkg::ducc_key_mode_t key_mode;
	ducc_pkg::ducc_sweep_t    rise_w;
	ducc_pkg::ducc_sweep_t    fall_w;

	// synchronisers for pin inputs
	logic [1:0] ps_s1_reg;
	logic [1:0] ps_s2_reg;
	logic       key_s1_reg;
	logic       key_s2_reg;
	logic       sync_s1_reg;
	logic       sync_s2_reg;
	logic       sync_prev_reg;
	logic       upd_s1_reg;
	logic       upd_s2_reg;
	logic       upd_prev_reg;
	logic       update_pulse;
	logic [13:0] ramp_scalar;
	logic        timer_reload;
	logic [27:0] scaled;

	// decode of the control bits into fields
	function automatic ducc_pkg::ducc_ctrl_t decode_ctrl(input logic [31:0] w);
		ducc_pkg::ducc_ctrl_t c;
		c.ram_en             = w[ducc_pkg::BIT_RAM_EN];
		c.ram_to_phase       = w[ducc_pkg::BIT_RAM_DEST];
		c.int_profile        = w[ducc_pkg::BIT_PROF_HI:ducc_pkg::BIT_PROF_LO];
		c.arr_load_on_update = w[ducc_pkg::BIT_ARR_LOAD];
		c.osk_en             = w[ducc_pkg::BIT_OSK_EN];
		c.osk_auto           = w[ducc_pkg::BIT_OSK_AUTO];
		c.auto_sync          = w[ducc_pkg::BIT_AUTO_SYNC];
		c.sweep_en           = w[ducc_pkg::BIT_SWEEP_EN];
		return c;
	endfunction

	assign ctrl   = decode_ctrl(ctrl_reg);
	// rising and falling words split into delta and ramp rate
	assign rise_w = ducc_pkg::ducc_sweep_t'(rise_reg);
	assign fall_w = ducc_pkg::ducc_sweep_t'(fall_reg);

	// ==========================================
	// input synchronisers
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ps_s1_reg   <= 2'h0;
			ps_s2_reg   <= 2'h0;
			key_s1_reg  <= 1'b0;
			key_s2_reg  <= 1'b0;
			sync_s1_reg <= 1'b0;
			sync_s2_reg <= 1'b0;
			upd_s1_reg  <= 1'b0;
			upd_s2_reg  <= 1'b0;
		end else begin
			ps_s1_reg   <= i_profile_select;
			ps_s2_reg   <= ps_s1_reg;
			key_s1_reg  <= i_keying_input;
			key_s2_reg  <= key_s1_reg;
			sync_s1_reg <= i_sync_in;
			sync_s2_reg <= sync_s1_reg;
			upd_s1_reg  <= i_update;
			upd_s2_reg  <= upd_s1_reg;
		end
	end

	// edge history for update and sync
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			upd_prev_reg  <= 1'b0;
			sync_prev_reg <= 1'b0;
		end else begin
			upd_prev_reg  <= upd_s2_reg;
			sync_prev_reg <= sync_s2_reg;
		end
	end

	assign update_pulse = upd_s2_reg && !upd_prev_reg;

	// ==========================================
	// serial-side shadow writes
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_shadow_reg   <= ducc_pkg::RST_CTRL_ONE;
			tuning_shadow_reg <= ducc_pkg::RST_TUNING_ONE;
			fall_shadow_reg   <= ducc_pkg::RST_SWEEP;
			rise_shadow_reg   <= ducc_pkg::RST_SWEEP;
		end else if (i_wr_en) begin
			case (i_wr_addr)
				ducc_pkg::ADDR_CTRL_ONE:   ctrl_shadow_reg   <= i_wr_data[31:0];
				ducc_pkg::ADDR_TUNING_ONE: tuning_shadow_reg <= i_wr_data[31:0];
				ducc_pkg::ADDR_FALL_SWEEP: fall_shadow_reg   <= i_wr_data;
				// top byte lands in bits 39:32 (ramp rate)
				ducc_pkg::ADDR_RISE_SWEEP: rise_shadow_reg   <= i_wr_data;
				default: ;
			endcase
		end
	end

	// ==========================================
	// update strobe moves shadows to active together
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_reg   <= ducc_pkg::RST_CTRL_ONE;
			tuning_reg <= ducc_pkg::RST_TUNING_ONE;
			fall_reg   <= ducc_pkg::RST_SWEEP;
			rise_reg   <= ducc_pkg::RST_SWEEP;
		end else if (update_pulse) begin
			ctrl_reg   <= ctrl_shadow_reg;
			tuning_reg <= tuning_shadow_reg;
			fall_reg   <= fall_shadow_reg;
			rise_reg   <= rise_shadow_reg;
		end
	end

	// registered readback of the serial-side copies
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rd_data <= 40'h00_0000_0000;
		end else begin
			case (i_rd_addr)
				ducc_pkg::ADDR_CTRL_ONE:   o_rd_data <= {8'h00, ctrl_shadow_reg};
				ducc_pkg::ADDR_TUNING_ONE: o_rd_data <= {8'h00, tuning_shadow_reg};
				ducc_pkg::ADDR_FALL_SWEEP: o_rd_data <= fall_shadow_reg;
				ducc_pkg::ADDR_RISE_SWEEP: o_rd_data <= rise_shadow_reg;
				default:                   o_rd_data <= 40'h00_0000_0000;
			endcase
		end
	end

	// ==========================================
	// ram routing and profile selection
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ram_active      <= 1'b0;
			o_ram_freq_word   <= 32'h0000_0000;
			o_ram_phase_word  <= 32'h0000_0000;
			o_ram_freq_valid  <= 1'b0;
			o_ram_phase_valid <= 1'b0;
			o_profile         <= 2'h0;
		end else begin
			// ram idle when disabled; active when enabled
			o_ram_active      <= ctrl.ram_en;
			o_ram_freq_valid  <= ctrl.ram_en && !ctrl.ram_to_phase;
			if (ctrl.ram_en && !ctrl.ram_to_phase) begin
				o_ram_freq_word <= i_ram_word;
			end
			o_ram_phase_valid <= ctrl.ram_en && ctrl.ram_to_phase;
			if (ctrl.ram_en && ctrl.ram_to_phase) begin
				o_ram_phase_word <= i_ram_word;
			end
			if (ctrl.ram_en && ctrl.int_profile != 3'h0) begin
				o_profile <= i_internal_profile;
			end else begin
				o_profile <= ps_s2_reg;
			end
		end
	end

	// ==========================================
	// tuning word and linear sweep selection
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_tuning_word_one <= 32'h0000_0000;
			o_sweep_active    <= 1'b0;
			o_sweep_delta     <= 32'h0000_0000;
			o_sweep_rate      <= 8'h00;
		end else begin
			o_tuning_word_one <= tuning_reg;
			o_sweep_active    <= ctrl.sweep_en && !ctrl.ram_en;
			o_sweep_delta     <= ps_s2_reg[0] ? rise_w.delta : fall_w.delta;
			o_sweep_rate      <= ps_s2_reg[0] ? rise_w.ramp_rate : fall_w.ramp_rate;
		end
	end

	// ==========================================
	// keying mode decode
	always_comb begin
		if (!ctrl.osk_en) begin
			key_mode = ducc_pkg::DUCC_KEY_BYPASS;
		end else if (ctrl.osk_auto) begin
			key_mode = ducc_pkg::DUCC_KEY_AUTO;
		end else begin
			key_mode = ducc_pkg::DUCC_KEY_MANUAL;
		end
	end

	// timer reload policy from load bit
	ducc_amp_ramp u_amp_ramp (
		.i_core_clk       (i_core_clk),
		.i_rst            (i_rst),
		.i_load_on_update (ctrl.arr_load_on_update),
		.i_update         (update_pulse),
		.i_auto           (key_mode == ducc_pkg::DUCC_KEY_AUTO),
		.i_key_level      (key_s2_reg),
		.i_ramp_rate      (8'h04),
		.i_scale          (i_amplitude_scale_factor),
		.o_scalar         (ramp_scalar),
		.o_timer_reload   (timer_reload)
	);

	// scaling of the amplitude sample
	always_comb begin
		case (key_mode)
			ducc_pkg::DUCC_KEY_MANUAL: scaled = i_sample * i_amplitude_scale_factor;
			ducc_pkg::DUCC_KEY_AUTO:   scaled = i_sample * ramp_scalar;
			default:                   scaled = {i_sample, 14'h0000};
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_dac_sample    <= 14'h0000;
			o_keying_scalar <= 14'h0000;
		end else begin
			o_dac_sample    <= scaled[27:14];
			o_keying_scalar <= ramp_scalar;
		end
	end

	// ==========================================
	// auto sync aligns on rising sync input edges
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_auto_sync_active <= 1'b0;
			o_sync_align       <= 1'b0;
		end else begin
			o_auto_sync_active <= ctrl.auto_sync;
			o_sync_align       <= ctrl.auto_sync && sync_s2_reg && !sync_prev_reg;
		end
	end

	// ==========================================
	// checks
	// frequency route follows control
	a_ram_freq_route: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_ram_freq_valid |-> $past(ctrl.ram_en) && !$past(ctrl.ram_to_phase))
		else $error("ram freq route wrong");
	a_ram_phase_route: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_ram_phase_valid |-> $past(ctrl.ram_en) && $past(ctrl.ram_to_phase))
		else $error("ram phase route wrong");
	a_ram_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!$past(ctrl.ram_en) |-> !o_ram_active && !o_ram_freq_valid && !o_ram_phase_valid)
		else $error("ram active while disabled");
	// active copy moves only on update
	a_update_only: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!$past(update_pulse) |-> $stable(ctrl_reg))
		else $error("control changed without update");
	// no update reload with load bit low
	a_no_upd_reload: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!ctrl.arr_load_on_update && update_pulse && timer_reload
		|-> u_amp_ramp.timer_reg == ducc_pkg::TIMER_RELOAD_AT)
		else $error("timer reloaded by update");
	// update reload with load bit high
	a_upd_reload: assert property (@(posedge i_core_clk) disable iff (i_rst)
		ctrl.arr_load_on_update && update_pulse |-> timer_reload)
		else $error("timer not reloaded by update");
	// scalar never rises with key low
	a_ramp_down: assert property (@(posedge i_core_clk) disable iff (i_rst)
		key_mode == ducc_pkg::DUCC_KEY_AUTO && !key_s2_reg ##1 key_mode == ducc_pkg::DUCC_KEY_AUTO
		|-> ramp_scalar <= $past(ramp_scalar))
		else $error("scalar rose with key low");
	// no alignment while auto sync off
	a_sync_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!$past(ctrl.auto_sync) |-> !o_sync_align)
		else $error("sync align while disabled");

endmodule

// file: verilog/ducc_pkg.sv
package ducc_pkg;

	// ==========================================
	// serial addresses of the block's registers
	localparam logic [4:0] ADDR_CTRL_ONE    = 5'h00;
	localparam logic [4:0] ADDR_TUNING_ONE  = 5'h06;
	localparam logic [4:0] ADDR_FALL_SWEEP  = 5'h07;
	localparam logic [4:0] ADDR_RISE_SWEEP  = 5'h08;

	// ==========================================
	// control_function_one upper field positions
	localparam int BIT_RAM_EN      = 31;
	localparam int BIT_RAM_DEST    = 30;
	localparam int BIT_PROF_HI     = 29;
	localparam int BIT_PROF_LO     = 27;
	localparam int BIT_ARR_LOAD    = 26;
	localparam int BIT_OSK_EN      = 25;
	localparam int BIT_OSK_AUTO    = 24;
	localparam int BIT_AUTO_SYNC   = 23;
	localparam int BIT_SWEEP_EN    = 21;

	// ==========================================
	// sweep control word layout
	localparam int SWP_DELTA_HI    = 31;
	localparam int SWP_RATE_LO     = 32;
	localparam int SWP_RATE_HI     = 39;

	// ==========================================
	// reset values
	localparam logic [31:0] RST_CTRL_ONE   = 32'h0000_0000;
	localparam logic [31:0] RST_TUNING_ONE = 32'h0000_0000;
	localparam logic [39:0] RST_SWEEP      = 40'h00_0000_0000;
	localparam logic [13:0] RST_SCALE      = 14'h0000;
	localparam logic [7:0]  RST_RAMP_TIMER = 8'h01;
	localparam logic [7:0]  TIMER_RELOAD_AT = 8'h01;

	// ==========================================
	// keying modes
	typedef enum logic [1:0] {
		DUCC_KEY_BYPASS,
		DUCC_KEY_MANUAL,
		DUCC_KEY_AUTO
	} ducc_key_mode_t;

	// decoded view of the upper control bits
	typedef struct packed {
		logic       ram_en;
		logic       ram_to_phase;
		logic [2:0] int_profile;
		logic       arr_load_on_update;
		logic       osk_en;
		logic       osk_auto;
		logic       auto_sync;
		logic       sweep_en;
	} ducc_ctrl_t;

	// sweep word split into its two fields
	typedef struct packed {
		logic [7:0]  ramp_rate;
		logic [31:0] delta;
	} ducc_sweep_t;

endpackage

// file: verilog/ducc_amp_ramp.sv
`timescale 1ns/10ps

// ==========================================
// amplitude ramp-rate timer and keying scalar
module ducc_amp_ramp (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic        i_load_on_update,
	input  wire logic        i_update,
	input  wire logic        i_auto,
	input  wire logic        i_key_level,
	input  wire logic [7:0]  i_ramp_rate,
	input  wire logic [13:0] i_scale,
	output logic      [13:0] o_scalar,
	output logic             o_timer_reload
);

	logic [7:0]  timer_reg;
	logic        reload;

	// reload on timeout, or on update when enabled
	assign reload         = (timer_reg == ducc_pkg::TIMER_RELOAD_AT) ||
	                        (i_load_on_update && i_update);
	assign o_timer_reload = reload;

	// ramp-rate down counter
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			timer_reg <= ducc_pkg::RST_RAMP_TIMER;
		end else if (reload) begin
			timer_reg <= (i_ramp_rate == 8'h00) ? 8'h01 : i_ramp_rate;
		end else begin
			timer_reg <= timer_reg - 8'h01;
		end
	end

	// scalar steps once per timeout toward target, dropping straight to scale if above it with key high
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_scalar <= ducc_pkg::RST_SCALE;
		end else if (!i_auto) begin
			o_scalar <= ducc_pkg::RST_SCALE;
		end else if (timer_reg == ducc_pkg::TIMER_RELOAD_AT) begin
			if (i_key_level && o_scalar < i_scale) begin
				o_scalar <= o_scalar + 14'h0001;
			end else if (i_key_level && o_scalar > i_scale) begin
				o_scalar <= i_scale;
			end else if (!i_key_level && o_scalar != 14'h0000) begin
				o_scalar <= o_scalar - 14'h0001;
			end
		end
	end

endmodule

// file: tb/ducc_host_model.sv
`timescale 1ns/10ps

// ==========================================
// host model: register writes and update strobe
module ducc_host_model (
	input  wire logic        i_core_clk,
	output logic             o_wr_en,
	output logic [4:0]       o_wr_addr,
	output logic [39:0]      o_wr_data,
	output logic             o_update
);
	// idle bus at time zero
	initial begin
		o_wr_en = 1'b0;
		o_wr_addr = 5'h1f;
		o_wr_data = 40'h00_0000_0000;
		o_update = 1'b0;
	end

	// one write, four-cycle update strobe; released bus shows inverse
	task automatic write(input logic [4:0] addr, input logic [39:0] data);
		@(posedge i_core_clk);
		o_wr_en <= 1'b1;
		o_wr_addr <= addr;
		o_wr_data <= data;
		@(posedge i_core_clk);
		o_wr_en <= 1'b0;
		o_wr_addr <= ~addr;
		o_wr_data <= ~data;
	endtask

	task automatic strobe();
		@(posedge i_core_clk);
		o_update <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		o_update <= 1'b0;
		repeat (6) @(posedge i_core_clk);
	endtask
endmodule

// file: tb/ducc_top_tb.sv
`timescale 1ns/10ps

`define CHK(g, e) chk_val(40'(g), 40'(e))

// ==========================================
// bench for the upper control bank
module ducc_top_tb;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [1:0]  ps;
		logic        ram;
		logic        swp;
		logic        sync;
		logic [1:0]  prof;
	} ducc_row_t;

	// control word, pins, expected mode outputs
	localparam ducc_row_t ROWS [0:6] = '{
		'{32'h0000_0000, 2'h1, 1'b0, 1'b0, 1'b0, 2'h1},
		'{32'h0020_0000, 2'h2, 1'b0, 1'b1, 1'b0, 2'h2},
		'{32'h8020_0000, 2'h3, 1'b1, 1'b0, 1'b0, 2'h3},
		'{32'h0080_0000, 2'h0, 1'b0, 1'b0, 1'b1, 2'h0},
		'{32'h8800_0000, 2'h1, 1'b1, 1'b0, 1'b0, 2'h2},
		'{32'h0800_0000, 2'h1, 1'b0, 1'b0, 1'b0, 2'h1},
		'{32'hb800_0000, 2'h0, 1'b1, 1'b0, 1'b0, 2'h2}
	};

	logic        i_core_clk, i_rst, wr_en, upd, key, sync_in;
	logic [4:0]  wr_addr, rd_addr;
	logic [39:0] wr_data, o_rd_data;
	logic [1:0]  ps, o_profile;
	logic [13:0] scale, sample, o_dac_sample, o_keying_scalar;
	logic [31:0] ram_word, o_ram_freq_word, o_ram_phase_word, o_tuning_word_one;
	logic [31:0] o_sweep_delta;
	logic [7:0]  o_sweep_rate;
	logic        o_ram_active, o_ram_freq_valid, o_ram_phase_valid;
	logic        o_sweep_active, o_auto_sync_active, o_sync_align;
	int          n_fail, n_tests, cnt;

	ducc_host_model u_host (.i_core_clk(i_core_clk), .o_wr_en(wr_en),
		.o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_update(upd));

	ducc_top u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_wr_en(wr_en),
		.i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_rd_addr(rd_addr),
		.o_rd_data(o_rd_data), .i_update(upd), .i_profile_select(ps),
		.i_keying_input(key), .i_sync_in(sync_in), .i_amplitude_scale_factor(scale),
		.i_ram_word(ram_word), .i_internal_profile(2'h2), .i_sample(sample),
		.o_profile(o_profile), .o_ram_active(o_ram_active),
		.o_ram_freq_word(o_ram_freq_word), .o_ram_phase_word(o_ram_phase_word),
		.o_ram_freq_valid(o_ram_freq_valid), .o_ram_phase_valid(o_ram_phase_valid),
		.o_tuning_word_one(o_tuning_word_one), .o_sweep_active(o_sweep_active),
		.o_sweep_delta(o_sweep_delta), .o_sweep_rate(o_sweep_rate),
		.o_dac_sample(o_dac_sample), .o_keying_scalar(o_keying_scalar),
		.o_auto_sync_active(o_auto_sync_active), .o_sync_align(o_sync_align));

	// clock, 20 ns period
	initial begin
		i_core_clk = 1'b0;
		forever #10 i_core_clk = ~i_core_clk;
	end

	// compare and count
	task automatic chk_val(input logic [39:0] got, input logic [39:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// readback of a shadow register
	task automatic rd(input logic [4:0] a, input logic [39:0] exp);
		@(posedge i_core_clk);
		rd_addr <= a;
		repeat (2) @(negedge i_core_clk);
		`CHK(o_rd_data, exp);
	endtask

	// control write then update
	task automatic ctrl(input logic [31:0] c);
		u_host.write(ducc_pkg::ADDR_CTRL_ONE, {8'h00, c});
		u_host.strobe();
		@(negedge i_core_clk);
	endtask

	// one sync edge, count alignment pulses
	task automatic sync_edge();
		cnt = 0;
		@(posedge i_core_clk);
		sync_in <= 1'b1;
		repeat (10) begin
			@(negedge i_core_clk);
			if (o_sync_align === 1'b1) cnt++;
		end
		@(posedge i_core_clk);
		sync_in <= 1'b0;
		repeat (4) @(posedge i_core_clk);
	endtask

	task automatic give_verdict();
		$display("tests=%0d fails=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// watchdog
	initial begin
		#200us;
		n_fail++;
		give_verdict();
	end

	// main sequence
	initial begin
		n_fail = 0;
		n_tests = 0;
		i_rst = 1'b1;
		rd_addr = ducc_pkg::ADDR_CTRL_ONE;
		ps = 2'h0;
		key = 1'b0;
		sync_in = 1'b0;
		scale = 14'h2000;
		sample = 14'h1234;
		ram_word = 32'hdead_beef;
		repeat (2) @(posedge i_core_clk);
		@(negedge i_core_clk);
		`CHK(o_rd_data, 40'h0);
		`CHK(o_tuning_word_one, 32'h0);
		`CHK({o_ram_active, o_sweep_active, o_auto_sync_active}, 3'h0);
		@(posedge i_core_clk);
		i_rst <= 1'b0;
		// table of mode rows
		for (int i = 0; i < 7; i++) begin
			@(posedge i_core_clk);
			ps <= ROWS[i].ps;
			ctrl(ROWS[i].ctrl);
			`CHK(o_ram_active, ROWS[i].ram);
			`CHK(o_sweep_active, ROWS[i].swp);
			`CHK(o_auto_sync_active, ROWS[i].sync);
			`CHK(o_profile, ROWS[i].prof);
			rd(ducc_pkg::ADDR_CTRL_ONE, {8'h00, ROWS[i].ctrl});
		end
		// sweep words, layout and direction
		u_host.write(ducc_pkg::ADDR_RISE_SWEEP, 40'h5a_1122_3344);
		u_host.write(ducc_pkg::ADDR_FALL_SWEEP, 40'h3c_aabb_ccdd);
		rd(ducc_pkg::ADDR_RISE_SWEEP, 40'h5a_1122_3344);
		rd(ducc_pkg::ADDR_FALL_SWEEP, 40'h3c_aabb_ccdd);
		@(posedge i_core_clk);
		ps <= 2'h1;
		ctrl(32'h0020_0000);
		`CHK(o_sweep_delta[31:24], 8'h11);
		`CHK(o_sweep_delta, 32'h1122_3344);
		`CHK(o_sweep_rate, 8'h5a);
		@(posedge i_core_clk);
		ps <= 2'h0;
		repeat (6) @(negedge i_core_clk);
		`CHK(o_sweep_delta, 32'haabb_ccdd);
		`CHK(o_sweep_rate, 8'h3c);
		// active copy waits for update
		u_host.write(ducc_pkg::ADDR_TUNING_ONE, 40'hff_1357_9bdf);
		rd(ducc_pkg::ADDR_TUNING_ONE, 40'h00_1357_9bdf);
		rd(5'h1f, 40'h0);
		`CHK(o_tuning_word_one, 32'h0);
		u_host.strobe();
		@(negedge i_core_clk);
		`CHK(o_tuning_word_one, 32'h1357_9bdf);
		// ram destination routing
		ctrl(32'h4000_0000);
		`CHK({o_ram_freq_valid, o_ram_phase_valid}, 2'h0);
		ctrl(32'h8000_0000);
		`CHK({o_ram_freq_valid, o_ram_phase_valid}, 2'h2);
		`CHK(o_ram_freq_word, 32'hdead_beef);
		ctrl(32'hc000_0000);
		`CHK({o_ram_freq_valid, o_ram_phase_valid}, 2'h1);
		`CHK(o_ram_phase_word, 32'hdead_beef);
		// keying bypass, manual, auto bit alone
		ctrl(32'h0000_0000);
		`CHK(o_dac_sample, 14'h1234);
		ctrl(32'h0200_0000);
		`CHK(o_dac_sample, 14'h091a);
		ctrl(32'h0100_0000);
		`CHK(o_dac_sample, 14'h1234);
		// automatic ramp up and down
		@(posedge i_core_clk);
		scale <= 14'h0003;
		ctrl(32'h0300_0000);
		`CHK(o_keying_scalar, 14'h0);
		@(posedge i_core_clk);
		key <= 1'b1;
		repeat (6) @(negedge i_core_clk);
		`CHK(o_keying_scalar < 14'h0003, 1'b1);
		repeat (40) @(negedge i_core_clk);
		`CHK(o_keying_scalar, 14'h0003);
		@(posedge i_core_clk);
		key <= 1'b0;
		repeat (40) @(negedge i_core_clk);
		`CHK(o_keying_scalar, 14'h0);
		// load bit set: second update reloads the ramp timer
		ctrl(32'h0700_0000);
		ctrl(32'h0700_0000);
		`CHK(o_keying_scalar, 14'h0);
		@(posedge i_core_clk);
		key <= 1'b1;
		repeat (40) @(negedge i_core_clk);
		`CHK(o_keying_scalar, 14'h0003);
		@(posedge i_core_clk);
		key <= 1'b0;
		// sync alignment on and off
		ctrl(32'h0080_0000);
		sync_edge();
		`CHK(cnt, 1);
		ctrl(32'h0000_0000);
		sync_edge();
		`CHK(cnt, 0);
		// second reset in mid-run, then a first write after release
		@(posedge i_core_clk);
		i_rst <= 1'b1;
		rd_addr <= ducc_pkg::ADDR_TUNING_ONE;
		@(negedge i_core_clk);
		`CHK(o_tuning_word_one, 32'h0);
		`CHK(o_rd_data, 40'h0);
		@(posedge i_core_clk);
		i_rst <= 1'b0;
		u_host.write(ducc_pkg::ADDR_FALL_SWEEP, 40'h01_0203_0405);
		rd(ducc_pkg::ADDR_FALL_SWEEP, 40'h01_0203_0405);
		`CHK(o_sweep_delta, 32'h0);
		give_verdict();
	end
endmodule
